// file: hw/isc_pkg.sv
// Package: register map, fields, reset values and timing for the irq and sleep controller
`default_nettype none
package isc_pkg;
  // ==========================================================
  // Register byte addresses (printed offsets not all multiples of four: index * 4)
  localparam logic [7:0] IDX_MCU_CONTROL     = 8'h35;
  localparam logic [7:0] IDX_TIMER_IRQ_MASK  = 8'h39;
  localparam logic [7:0] IDX_TIMER_IRQ_FLAGS = 8'h38;
  localparam logic [7:0] IDX_IRQ_ENABLE      = 8'h3b;
  localparam logic [7:0] IDX_CPU_STATUS      = 8'h3f;
  localparam logic [7:0] IDX_CORE_STATE      = 8'h30;
  localparam logic [9:0] ADDR_MCU_CONTROL     = {IDX_MCU_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_TIMER_IRQ_MASK  = {IDX_TIMER_IRQ_MASK, 2'b00};
  localparam logic [9:0] ADDR_TIMER_IRQ_FLAGS = {IDX_TIMER_IRQ_FLAGS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_ENABLE      = {IDX_IRQ_ENABLE, 2'b00};
  localparam logic [9:0] ADDR_CPU_STATUS      = {IDX_CPU_STATUS, 2'b00};
  localparam logic [9:0] ADDR_CORE_STATE      = {IDX_CORE_STATE, 2'b00};
  // ==========================================================
  // Field positions
  localparam int BIT_SENSE_LO    = 0;
  localparam int BIT_SENSE_HI    = 1;
  localparam int BIT_SLEEP_KIND  = 4;
  localparam int BIT_SLEEP_ALLOW = 5;
  localparam int BIT_OVF_ENABLE  = 1;
  localparam int BIT_OVF_FLAG    = 1;
  localparam int BIT_EXT_ENABLE  = 6;
  localparam int BIT_GLOBAL_IE   = 7;
  localparam logic [7:0] MCU_CONTROL_MASK = 8'h33;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  // ==========================================================
  // Sense encodings
  localparam logic [1:0] SENSE_LOW  = 2'b00;
  localparam logic [1:0] SENSE_FALL = 2'b10;
  localparam logic [1:0] SENSE_RISE = 2'b11;
  // ==========================================================
  // Timing
  localparam int ENTRY_CYCLES  = 4;
  localparam int JUMP_CYCLES   = 2;
  localparam int RETURN_CYCLES = 4;
  localparam int WAKE_SAMPLES  = 2;
  localparam int STARTUP_DEFAULT = 16384;
  localparam logic [3:0] VEC_EXT = 4'h1;
  localparam logic [3:0] VEC_OVF = 4'h2;
  typedef enum logic [2:0] {
    ISC_RUN    = 3'b000,
    ISC_ENTRY  = 3'b001,
    ISC_JUMP   = 3'b011,
    ISC_RET    = 3'b010,
    ISC_ONE    = 3'b110,
    ISC_IDLE   = 3'b111,
    ISC_PDOWN  = 3'b101,
    ISC_WAKE   = 3'b100
  } isc_state_e;
endpackage
`default_nettype wire

// file: hw/isc_edge_if.sv
// Interface: sampled pin and trigger between edge detector and controller
`default_nettype none
interface isc_edge_if;
  logic [1:0] sense;
  logic       pin_level;
  logic       edge_hit;
  modport det (input sense, output pin_level, output edge_hit);
  modport ctl (output sense, input pin_level, input edge_hit);
endinterface
`default_nettype wire

// file: hw/isc_edge_det.sv
// Module: external pin sampler and edge detector
`default_nettype none
module isc_edge_det (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  isc_edge_if.det   eif
);
  import isc_pkg::*;
  logic smp;
  logic prev;
  logic next_smp;
  logic next_prev;
  logic next_hit;
  logic hit;
  // ==========================================================
  // Sample first, then compare with last sample
  always_comb begin
    next_smp  = pin;
    next_prev = smp;
    next_hit  = 1'b0;
    case (eif.sense)
      SENSE_FALL: next_hit = prev & ~smp;
      SENSE_RISE: next_hit = ~prev & smp;
      default:    next_hit = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp  <= 1'b1;
      prev <= 1'b1;
      hit  <= 1'b0;
    end else begin
      smp  <= next_smp;
      prev <= next_prev;
      hit  <= next_hit;
    end
  end
  assign eif.pin_level = smp;
  assign eif.edge_hit  = hit;
endmodule
`default_nettype wire

// file: hw/isc_ctrl.sv
// Module: interrupt and sleep control with APB register slave
//
// The APB register port was chosen for this implementation.
`default_nettype none
module isc_ctrl #(
  parameter int STARTUP_CYCLES = isc_pkg::STARTUP_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        ext_irq_pin,
  input  wire logic        timer_overflow,
  input  wire logic        wdt_tick,
  input  wire logic        instr_done,
  input  wire logic        sleep_instr,
  input  wire logic        irq_return_instr,
  output logic             irq_take,
  output logic [3:0]       irq_vector,
  output logic             pc_push,
  output logic             pc_pop,
  output logic             cpu_halt,
  output logic             osc_stop
);
  import isc_pkg::*;
  isc_edge_if eif ();
  isc_edge_det u_det (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_irq_pin),
    .eif     (eif)
  );
  // ==========================================================
  // Registers
  logic [7:0] mcu_control;
  logic       overflow_irq_enable;
  logic       overflow_flag;
  logic       ext_irq_enable;
  logic       ext_flag;
  logic       global_ie;
  logic [7:0] next_mcu_control;
  logic       next_ovf_en;
  logic       next_ovf_flag;
  logic       next_ext_en;
  logic       next_ext_flag;
  logic       next_gie;
  logic       next_pready;
  logic [31:0] next_prdata;
  logic       next_pslverr;
  isc_state_e state;
  isc_state_e next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [3:0]  vec;
  logic [3:0]  next_vec;
  logic [1:0]  wdt_ok;
  logic [1:0]  next_wdt_ok;
  logic       next_take;
  logic       next_push;
  logic       next_pop;
  logic       next_halt;
  logic       next_osc;
  logic       wr;
  logic       rd;
  logic       level_req;
  logic       ext_req;
  logic       ovf_req;
  function automatic logic hit(input logic [11:0] a, input logic [9:0] r);
    return a == {2'b00, r};
  endfunction
  always_comb begin
    wr = psel & penable & pwrite & pready;
    rd = psel & ~penable & ~pwrite;
    level_req = (mcu_control[1:0] == SENSE_LOW) & ~eif.pin_level;
    ext_req = ext_irq_enable & (ext_flag | level_req);
    ovf_req = overflow_irq_enable & overflow_flag;
  end
  assign eif.sense = mcu_control[BIT_SENSE_HI:BIT_SENSE_LO];
  // ==========================================================
  // Register next values; hardware set beats software clear
  always_comb begin
    next_mcu_control    = mcu_control;
    next_ovf_en         = overflow_irq_enable;
    next_ext_en         = ext_irq_enable;
    next_gie            = global_ie;
    next_ovf_flag       = overflow_flag;
    next_ext_flag       = ext_flag;
    next_pready         = psel & ~penable;
    // Read data is zero outside the access cycle, so a refusal never shows stale data
    next_prdata         = 32'h0000_0000;
    next_pslverr        = 1'b0;
    if (wr) begin
      if (hit(paddr, ADDR_MCU_CONTROL))
        next_mcu_control = pwdata[7:0] & MCU_CONTROL_MASK;
      if (hit(paddr, ADDR_TIMER_IRQ_MASK))
        next_ovf_en = pwdata[BIT_OVF_ENABLE];
      if (hit(paddr, ADDR_IRQ_ENABLE))
        next_ext_en = pwdata[BIT_EXT_ENABLE];
      if (hit(paddr, ADDR_CPU_STATUS))
        next_gie = pwdata[BIT_GLOBAL_IE];
      if (hit(paddr, ADDR_TIMER_IRQ_FLAGS) && pwdata[BIT_OVF_FLAG])
        next_ovf_flag = 1'b0;
    end
    if (rd) begin
      next_prdata = 32'h0000_0000;
      if (hit(paddr, ADDR_MCU_CONTROL))
        next_prdata[7:0] = mcu_control;
      else if (hit(paddr, ADDR_TIMER_IRQ_MASK))
        next_prdata[BIT_OVF_ENABLE] = overflow_irq_enable;
      else if (hit(paddr, ADDR_TIMER_IRQ_FLAGS))
        next_prdata[BIT_OVF_FLAG] = overflow_flag;
      else if (hit(paddr, ADDR_IRQ_ENABLE))
        next_prdata[BIT_EXT_ENABLE] = ext_irq_enable;
      else if (hit(paddr, ADDR_CPU_STATUS))
        next_prdata[BIT_GLOBAL_IE] = global_ie;
      else if (hit(paddr, ADDR_CORE_STATE))
        next_prdata[2:0] = state;
      else
        next_pslverr = 1'b1;
    end else if (psel & ~penable) begin
      next_pslverr = ~(hit(paddr, ADDR_MCU_CONTROL) | hit(paddr, ADDR_TIMER_IRQ_MASK) |
                       hit(paddr, ADDR_TIMER_IRQ_FLAGS) | hit(paddr, ADDR_IRQ_ENABLE) |
                       hit(paddr, ADDR_CPU_STATUS) | hit(paddr, ADDR_CORE_STATE));
    end
    // Level mode keeps no flag, so a stale edge is dropped
    if (mcu_control[1:0] == SENSE_LOW)
      next_ext_flag = 1'b0;
    if (state == ISC_ENTRY && cnt == 32'd0 && vec == VEC_OVF)
      next_ovf_flag = 1'b0;
    if (state == ISC_ENTRY && cnt == 32'd0 && vec == VEC_EXT)
      next_ext_flag = 1'b0;
    if (timer_overflow)
      next_ovf_flag = 1'b1;
    if (eif.edge_hit)
      next_ext_flag = 1'b1;
    if (state == ISC_ENTRY && cnt == 32'd0)
      next_gie = 1'b0;
    if (state == ISC_RET && cnt == 32'd0)
      next_gie = 1'b1;
  end
  // ==========================================================
  // Core sequencing: entry, jump, return, sleep
  always_comb begin
    next_state  = state;
    next_cnt    = (cnt == 32'd0) ? 32'd0 : cnt - 32'd1;
    next_vec    = vec;
    next_wdt_ok = wdt_ok;
    next_take   = 1'b0;
    next_push   = 1'b0;
    next_pop    = 1'b0;
    next_halt   = 1'b0;
    next_osc    = 1'b0;
    case (state)
      ISC_RUN: begin
        if (instr_done && global_ie && (ext_req || ovf_req)) begin
          next_state = ISC_ENTRY;
          next_vec   = ext_req ? VEC_EXT : VEC_OVF;
          next_cnt   = 32'(ENTRY_CYCLES - 1);
          next_push  = 1'b1;
          next_take  = 1'b1;
        end else if (instr_done && irq_return_instr) begin
          next_state = ISC_RET;
          next_cnt   = 32'(RETURN_CYCLES - 1);
          next_pop   = 1'b1;
        end else if (instr_done && sleep_instr && mcu_control[BIT_SLEEP_ALLOW]) begin
          next_state  = mcu_control[BIT_SLEEP_KIND] ? ISC_PDOWN : ISC_IDLE;
          next_halt   = 1'b1;
          next_osc    = mcu_control[BIT_SLEEP_KIND];
          next_wdt_ok = 2'b00;
        end
      end
      ISC_ENTRY: begin
        next_push = (cnt == 32'(ENTRY_CYCLES - 1));
        if (cnt == 32'd0) begin
          next_state = ISC_JUMP;
          next_cnt   = 32'(JUMP_CYCLES - 1);
        end
      end
      ISC_JUMP: begin
        if (cnt == 32'd0)
          next_state = ISC_RUN;
      end
      ISC_RET: begin
        next_pop = (cnt == 32'(RETURN_CYCLES - 1));
        if (cnt == 32'd0)
          next_state = ISC_ONE;
      end
      ISC_ONE: begin
        if (instr_done)
          next_state = ISC_RUN;
      end
      ISC_IDLE: begin
        next_halt = 1'b1;
        if (global_ie && (ext_req || ovf_req)) begin
          next_state = ISC_RUN;
          next_halt  = 1'b0;
        end
      end
      ISC_PDOWN: begin
        next_halt = 1'b1;
        next_osc  = 1'b1;
        // Only the level wakes; edges need the stopped clock
        if (wdt_tick)
          next_wdt_ok = {wdt_ok[0], level_req & ext_irq_enable};
        if (wdt_ok == 2'b11) begin
          next_state = ISC_WAKE;
          next_cnt   = 32'(STARTUP_CYCLES - 1);
        end
      end
      ISC_WAKE: begin
        next_halt = 1'b1;
        if (cnt == 32'd0) begin
          next_state = ISC_RUN;
          next_halt  = 1'b0;
        end
      end
      default: next_state = ISC_RUN;
    endcase
  end
  // ==========================================================
  // Registers; reset always lands in run, so it also wakes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_control         <= RESET_BYTE;
      overflow_irq_enable <= 1'b0;
      overflow_flag       <= 1'b0;
      ext_irq_enable      <= 1'b0;
      ext_flag            <= 1'b0;
      global_ie           <= 1'b0;
      pready              <= 1'b0;
      prdata              <= 32'h0000_0000;
      pslverr             <= 1'b0;
      state               <= ISC_RUN;
      cnt                 <= 32'h0000_0000;
      vec                 <= 4'h0;
      wdt_ok              <= 2'b00;
      irq_take            <= 1'b0;
      pc_push             <= 1'b0;
      pc_pop              <= 1'b0;
      cpu_halt            <= 1'b0;
      osc_stop            <= 1'b0;
    end else begin
      mcu_control         <= next_mcu_control;
      overflow_irq_enable <= next_ovf_en;
      overflow_flag       <= next_ovf_flag;
      ext_irq_enable      <= next_ext_en;
      ext_flag            <= next_ext_flag;
      global_ie           <= next_gie;
      pready              <= next_pready;
      prdata              <= next_prdata;
      pslverr             <= next_pslverr;
      state               <= next_state;
      cnt                 <= next_cnt;
      vec                 <= next_vec;
      wdt_ok              <= next_wdt_ok;
      irq_take            <= next_take;
      pc_push             <= next_push;
      pc_pop              <= next_pop;
      cpu_halt            <= next_halt;
      osc_stop            <= next_osc;
    end
  end
  assign irq_vector = vec;
endmodule
`default_nettype wire

// file: dv/isc_ctrl_props.sv
// Checker: port properties of the irq and sleep controller
`default_nettype none
module isc_ctrl_props #(
  parameter int STARTUP_CYCLES = 16384
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        sleep_instr,
  input wire logic        irq_take,
  input wire logic [3:0]  irq_vector,
  input wire logic        pc_push,
  input wire logic        pc_pop,
  input wire logic        cpu_halt,
  input wire logic        osc_stop
);
  import isc_pkg::*;
  // ==========
  // Bus and sequencing
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready held");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad refusal");
  property p_push; irq_take |-> pc_push ##1 pc_push; endproperty
  a_push: assert property (p_push) else $error("push not two bytes");
  // Entry and vector jump occupy six cycles, so no second take inside them
  property p_gap; irq_take |=> !irq_take [*5]; endproperty
  a_gap: assert property (p_gap) else $error("take too soon");
  property p_pop; $rose(pc_pop) |=> pc_pop ##1 !pc_pop; endproperty
  a_pop: assert property (p_pop) else $error("pop not two bytes");
  property p_vec; irq_take |-> irq_vector == VEC_EXT || irq_vector == VEC_OVF; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_halt; $rose(cpu_halt) |-> $past(sleep_instr); endproperty
  a_halt: assert property (p_halt) else $error("halt without sleep");
  property p_osc; osc_stop |-> cpu_halt; endproperty
  a_osc: assert property (p_osc) else $error("osc stop while running");
  c_ext: cover property (irq_take && irq_vector == VEC_EXT);
  c_ovf: cover property (irq_take && irq_vector == VEC_OVF);
  c_pd: cover property ($fell(osc_stop));
endmodule
bind isc_ctrl isc_ctrl_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .sleep_instr(sleep_instr), .irq_take(irq_take), .irq_vector(irq_vector), .pc_push(pc_push),
  .pc_pop(pc_pop), .cpu_halt(cpu_halt), .osc_stop(osc_stop));
`default_nettype wire

// file: dv/isc_core_model.sv
// Core model: instruction stream seen by the controller
`default_nettype none
module isc_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic cpu_halt,
  input  wire logic sleep_cmd,
  input  wire logic ret_cmd,
  output logic      instr_done,
  output logic      sleep_instr,
  output logic      irq_return_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Two-cycle instructions, so service always waits on completion
  logic next_done;
  always_comb next_done = !instr_done && !cpu_halt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) instr_done <= 1'h0;
    else instr_done <= next_done;
  end
  assign sleep_instr = sleep_cmd;
  assign irq_return_instr = ret_cmd;
endmodule
`default_nettype wire

// file: dv/isc_tb.sv
// Testbench: register, interrupt and sleep scenarios
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import isc_pkg::*;
  localparam int SU = 8;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        pin = 1'h1, ovf = 1'h0, tick = 1'h0, slp = 1'h0, ret = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, take, push, pop, halt, osc, done, sins, rins;
  logic [31:0] prdata;
  logic [3:0]  vec, lv;
  int          failures = 0, total_checks = 0, ntake = 0;
  wire logic [2:0] obs = {osc, halt, pop};
  isc_ctrl #(.STARTUP_CYCLES(SU)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_irq_pin(pin), .timer_overflow(ovf), .wdt_tick(tick), .instr_done(done), .sleep_instr(sins),
    .irq_return_instr(rins), .irq_take(take), .irq_vector(vec), .pc_push(push), .pc_pop(pop),
    .cpu_halt(halt), .osc_stop(osc));
  isc_core_model i_core (.pclk(pclk), .presetn(presetn), .cpu_halt(halt), .sleep_cmd(slp), .ret_cmd(ret),
    .instr_done(done), .sleep_instr(sins), .irq_return_instr(rins));
  initial forever #2 pclk = ~pclk;
  // Takes are counted on the falling edge so a pulse inside a bus cycle is not lost
  always @(negedge pclk) if (take === 1'h1) begin
    ntake++;
    lv = vec;
  end
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [31:0] x, input logic e);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, a};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    chk(pready, 1'h1);
    if (!w) chk(prdata, x);
    chk(pslverr, e);
    @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wt(input int b, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (obs[b] !== v && n < lim);
    chk(obs[b], v);
    @(posedge pclk);
  endtask
  task automatic hold(input int b, input logic v, input int c);
    repeat (c) begin
      @(negedge pclk);
      chk(obs[b], v);
    end
    @(posedge pclk);
  endtask
  task automatic wtake(input int k, input logic [3:0] v);
    int n;
    n = 0;
    while (ntake < k && n < 60) begin
      @(negedge pclk);
      n++;
    end
    chk(ntake, k);
    chk(lv, v);
    @(posedge pclk);
  endtask
  task automatic pulse(input logic t);
    if (t) tick <= 1'h1;
    else ovf <= 1'h1;
    @(posedge pclk);
    tick <= 1'h0;
    ovf <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rtn;
    ret <= 1'h1;
    wt(0, 1'h1, 40);
    ret <= 1'h0;
    wt(0, 1'h0, 10);
    // Global enable is restored at the last return cycle
    repeat (2) @(posedge pclk);
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    acc(0, ADDR_MCU_CONTROL, '0, '0, '0);
    acc(0, ADDR_TIMER_IRQ_MASK, '0, '0, '0);
    acc(1, ADDR_MCU_CONTROL, 8'hff, '0, '0);
    acc(0, ADDR_MCU_CONTROL, '0, 32'h33, '0);
    acc(1, ADDR_TIMER_IRQ_MASK, 8'hff, '0, '0);
    acc(0, ADDR_TIMER_IRQ_MASK, '0, 32'h2, '0);
    acc(1, 10'h4, 8'hff, '0, 1'h1);
    acc(0, 10'h4, '0, '0, 1'h1);
    acc(1, ADDR_MCU_CONTROL, '0, '0, '0);
    $display("t_regs done");
  endtask
  task automatic t_ovf;
    pulse(0);
    acc(0, ADDR_TIMER_IRQ_FLAGS, '0, 32'h2, '0);
    chk(ntake, 0);
    acc(1, ADDR_TIMER_IRQ_FLAGS, '0, '0, '0);
    acc(0, ADDR_TIMER_IRQ_FLAGS, '0, 32'h2, '0);
    acc(1, ADDR_TIMER_IRQ_FLAGS, 8'h2, '0, '0);
    acc(0, ADDR_TIMER_IRQ_FLAGS, '0, '0, '0);
    pulse(0);
    acc(1, ADDR_CPU_STATUS, 8'h80, '0, '0);
    wtake(1, VEC_OVF);
    // Flag and global enable drop at the last entry cycle, before the vector jump
    repeat (4) @(posedge pclk);
    acc(0, ADDR_TIMER_IRQ_FLAGS, '0, '0, '0);
    acc(0, ADDR_CPU_STATUS, '0, '0, '0);
    rtn;
    acc(0, ADDR_CPU_STATUS, '0, 32'h80, '0);
    $display("t_ovf done");
  endtask
  task automatic t_ext;
    acc(1, ADDR_CPU_STATUS, '0, '0, '0);
    acc(1, ADDR_MCU_CONTROL, {6'h0, SENSE_FALL}, '0, '0);
    acc(1, ADDR_IRQ_ENABLE, 8'h40, '0, '0);
    pulse(0);
    pin <= 1'h0;
    repeat (2) @(posedge pclk);
    pin <= 1'h1;
    chk(ntake, 1);
    acc(1, ADDR_CPU_STATUS, 8'h80, '0, '0);
    wtake(2, VEC_EXT);
    rtn;
    wtake(3, VEC_OVF);
    rtn;
    acc(1, ADDR_MCU_CONTROL, {6'h0, SENSE_RISE}, '0, '0);
    pin <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(ntake, 3);
    pin <= 1'h1;
    wtake(4, VEC_EXT);
    rtn;
    acc(1, ADDR_MCU_CONTROL, {6'h0, SENSE_LOW}, '0, '0);
    pin <= 1'h0;
    wtake(5, VEC_EXT);
    rtn;
    wtake(6, VEC_EXT);
    pin <= 1'h1;
    rtn;
    $display("t_ext done");
  endtask
  task automatic t_sleep;
    acc(1, ADDR_IRQ_ENABLE, '0, '0, '0);
    acc(1, ADDR_MCU_CONTROL, '0, '0, '0);
    slp <= 1'h1;
    hold(1, 1'h0, 8);
    slp <= 1'h0;
    acc(1, ADDR_MCU_CONTROL, 8'h20, '0, '0);
    slp <= 1'h1;
    wt(1, 1'h1, 20);
    slp <= 1'h0;
    hold(2, 1'h0, 3);
    pulse(0);
    wtake(7, VEC_OVF);
    wt(1, 1'h0, 10);
    rtn;
    $display("t_sleep done");
  endtask
  task automatic t_pdown;
    acc(1, ADDR_IRQ_ENABLE, 8'h40, '0, '0);
    acc(1, ADDR_MCU_CONTROL, 8'h30, '0, '0);
    slp <= 1'h1;
    wt(2, 1'h1, 20);
    slp <= 1'h0;
    pulse(0);
    hold(1, 1'h1, 4);
    // The pin is sampled once before the level is seen, so each level leads its tick by a cycle
    pin <= 1'h0;
    @(posedge pclk);
    pulse(1);
    pin <= 1'h1;
    @(posedge pclk);
    pulse(1);
    hold(2, 1'h1, 4);
    pin <= 1'h0;
    @(posedge pclk);
    pulse(1);
    pulse(1);
    hold(1, 1'h1, 3);
    wtake(8, VEC_EXT);
    pin <= 1'h1;
    rtn;
    wtake(9, VEC_OVF);
    rtn;
    slp <= 1'h1;
    wt(2, 1'h1, 20);
    slp <= 1'h0;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    wt(1, 1'h0, 3);
    acc(0, ADDR_MCU_CONTROL, '0, '0, '0);
    $display("t_pdown done");
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs;
    t_ovf;
    t_ext;
    t_sleep;
    t_pdown;
    end_sim;
  end
  initial begin
    #100us;
    failures++;
    $display("ERROR %0t: timeout", $time);
    end_sim;
  end
endmodule
`default_nettype wire
